/* File: src/fhl_pkg.sv */
package fhl_pkg;
	// Log depth and field widths
	localparam int HIST_DEPTH = 10;
	localparam int CODE_W = 8;
	localparam int SUB_W = 16;
	localparam int DATE_W = 16;
	localparam int TIME_W = 16;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int SLOT_W = 4;
	localparam int MON_W = 16;
	localparam int MON_COUNT = 18;

	// Register map, word indices
	localparam logic [ADDR_W-1:0] OFS_CODE_BASE = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_DATE_BASE = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_TIME_BASE = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_SUB_BASE = 6'h30;
	localparam logic [ADDR_W-1:0] OFS_BEHAV_CFG = 6'h0a;
	localparam logic [ADDR_W-1:0] OFS_HIST_CMD = 6'h0b;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_FAULT_CLR = 6'h0d;

	// Field positions and values
	localparam int CFG_NO_FREEZE_BIT = 4;
	localparam logic [DATA_W-1:0] CMD_CLEAR_ALL = 16'h00ff;
	localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] FAULT_CLR_KEY = 16'h0001;

	// One logged entry
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic [SUB_W-1:0] sub;
		logic [DATE_W-1:0] date;
		logic [TIME_W-1:0] tod;
	} fhl_entry_t;

	// Fault event from protection logic
	typedef struct packed {
		logic strobe;
		logic [CODE_W-1:0] code;
		logic [SUB_W-1:0] sub;
		logic has_sub;
	} fhl_event_t;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fhl_req_t;

	// Fault lifecycle
	typedef enum logic [0:0] {
		FHL_RUN = 1'b0,
		FHL_TRIPPED = 1'b1
	} fhl_state_t;
endpackage

/* File: src/fhl_monitor_hold.sv */
`timescale 1ns/1ns
// Holds the monitoring values while frozen, passes them through otherwise
module fhl_monitor_hold #(
	parameter int WIDTH = 16,
	parameter int COUNT = 18
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic freeze_i,
	input wire logic [COUNT*WIDTH-1:0] live_i,
	output logic [COUNT*WIDTH-1:0] held_o
);
	// One held register per value
	genvar g;
	generate
		for (g = 0; g < COUNT; g++) begin : g_val
			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					held_o[g*WIDTH +: WIDTH] <= '0;
				end else if (!freeze_i) begin
					held_o[g*WIDTH +: WIDTH] <= live_i[g*WIDTH +: WIDTH];
				end
			end
		end
	endgenerate
endmodule

/* File: src/fhl_core.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Ten fault slots, newest to oldest
// - New fault enters newest, others shift, oldest lost
// - Date and time captured, shift alongside
// - Sub-code shifts alongside, zero if none
// - Reading a slot returns its code
// - Writing 255 to command clears all logs
// - Any fault disables power output
// - Monitoring values frozen until fault cleared
// - Config bit 4 disables the freeze
module fhl_core #(
	parameter int DEPTH = fhl_pkg::HIST_DEPTH
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire fhl_pkg::fhl_event_t FAULT_I,
	input wire logic [fhl_pkg::DATE_W-1:0] DATE_I,
	input wire logic [fhl_pkg::TIME_W-1:0] TIME_I,
	input wire fhl_pkg::fhl_req_t REQ_I,
	output logic [fhl_pkg::DATA_W-1:0] RDATA_O,
	output logic OUTPUT_EN_O,
	output logic FROZEN_O,
	input wire logic [fhl_pkg::MON_COUNT*fhl_pkg::MON_W-1:0] MON_LIVE_I,
	output logic [fhl_pkg::MON_COUNT*fhl_pkg::MON_W-1:0] MON_HELD_O
);
	import fhl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	fhl_entry_t hist [DEPTH]; // Slot 0 newest
	logic [DATA_W-1:0] behav_cfg; // Fault behaviour configuration
	fhl_state_t state; // Run or tripped
	fhl_state_t next_state;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire wr_cmd = REQ_I.wr && (REQ_I.addr == OFS_HIST_CMD);
	wire wr_cfg = REQ_I.wr && (REQ_I.addr == OFS_BEHAV_CFG);
	wire wr_fclr = REQ_I.wr && (REQ_I.addr == OFS_FAULT_CLR);
	wire clear_all = wr_cmd && (REQ_I.wdata == CMD_CLEAR_ALL);
	wire fault_clear = wr_fclr && (REQ_I.wdata == FAULT_CLR_KEY);
	// Slot address: high bits pick the field, low bits the slot
	wire [1:0] region = REQ_I.addr[5:4];
	wire [3:0] slot = REQ_I.addr[3:0];
	wire slot_ok = (slot < SLOT_W'(DEPTH));
	wire fault_in = FAULT_I.strobe;
	wire no_freeze = behav_cfg[CFG_NO_FREEZE_BIT];

	// New entry, sub-code zero when absent
	fhl_entry_t new_entry;
	assign new_entry.code = FAULT_I.code;
	assign new_entry.sub = FAULT_I.has_sub ? FAULT_I.sub : '0;
	assign new_entry.date = DATE_I;
	assign new_entry.tod = TIME_I;

	////////////////////////////////////////////////////////////////////////
	// History shift register, one generate stage per slot
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_slot
			// Value this slot takes on a fault
			fhl_entry_t shift_in;
			if (g == 0) begin : g_head
				assign shift_in = new_entry;
			end else begin : g_tail
				// A clear in the fault cycle empties all but the new entry
				assign shift_in = clear_all ? '0 : hist[g-1];
			end
			// Shift on a fault, wipe on a clear
			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					hist[g] <= '0;
				end else if (fault_in) begin
					// A fault in the clear cycle still logs
					hist[g] <= shift_in;
				end else if (clear_all) begin
					hist[g] <= '0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Fault lifecycle
	// Trip on any fault, leave only by a clear write
	always_comb begin
		next_state = state;
		unique case (state)
			FHL_RUN: begin
				if (fault_in) begin
					next_state = FHL_TRIPPED;
				end
			end
			FHL_TRIPPED: begin
				// New fault beats clear
				if (fault_clear && !fault_in) begin
					next_state = FHL_RUN;
				end
			end
		endcase
	end

	// State and configuration registers
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state <= FHL_RUN;
			behav_cfg <= CFG_RESET;
		end else begin
			state <= next_state;
			if (wr_cfg) begin
				behav_cfg <= REQ_I.wdata;
			end
		end
	end

	// Power stage off in the strobe cycle and while tripped
	assign OUTPUT_EN_O = (state == FHL_RUN) && !fault_in;
	assign FROZEN_O = (state == FHL_TRIPPED) && !no_freeze;

	////////////////////////////////////////////////////////////////////////
	// Monitoring hold; freeze starts on the fault strobe itself
	wire mon_freeze = (FROZEN_O || fault_in) && !no_freeze;
	fhl_monitor_hold #(
		.WIDTH(MON_W),
		.COUNT(MON_COUNT)
	) u_hold (
		.CLK_I(CLK_I),
		.RESET_N_I(RESET_N_I),
		.freeze_i(mon_freeze),
		.live_i(MON_LIVE_I),
		.held_o(MON_HELD_O)
	);

	////////////////////////////////////////////////////////////////////////
	// Read mux
	fhl_entry_t rd_entry;
	logic [DATA_W-1:0] next_rdata;
	assign rd_entry = slot_ok ? hist[slot] : '0;

	// Select the word of the addressed register
	always_comb begin
		next_rdata = '0;
		if (REQ_I.addr == OFS_BEHAV_CFG) begin
			next_rdata = behav_cfg;
		end else if (REQ_I.addr == OFS_STATUS) begin
			next_rdata = {14'h0000, FROZEN_O, state == FHL_TRIPPED};
		end else if (slot_ok) begin
			unique case (region)
				2'h0: next_rdata = {8'h00, rd_entry.code};
				2'h1: next_rdata = rd_entry.date;
				2'h2: next_rdata = rd_entry.tod;
				2'h3: next_rdata = rd_entry.sub;
			endcase
		end
	end

	// Read data valid the cycle after the strobe only
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= '0;
		end else begin
			RDATA_O <= REQ_I.rd ? next_rdata : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	// History entry and shift
	a_newest_code: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fault_in |=> hist[0].code == $past(FAULT_I.code))
		else $error("newest slot missed code");
	a_shift_step: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fault_in && !clear_all |=> hist[DEPTH-1] == $past(hist[DEPTH-2]))
		else $error("history did not shift");
	a_date_capture: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fault_in |=> hist[0].date == $past(DATE_I) && hist[0].tod == $past(TIME_I))
		else $error("date or time not captured");
	a_sub_zero: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fault_in && !FAULT_I.has_sub |=> hist[0].sub == '0)
		else $error("absent sub-code not zero");
	a_one_entry: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		!fault_in && !clear_all |=> hist[1] == $past(hist[1]))
		else $error("log moved without strobe");
	// Register side
	a_read_code: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		REQ_I.rd && REQ_I.addr == OFS_CODE_BASE && !fault_in && !clear_all
		|=> RDATA_O == {8'h00, hist[0].code})
		else $error("slot read wrong code");
	a_rdata_idle: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		!REQ_I.rd |=> RDATA_O == '0)
		else $error("read data outside its cycle");
	a_clear_wipes: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		clear_all && !fault_in |=> hist[DEPTH-1] == '0 && hist[0] == '0)
		else $error("clear left entries");
	a_clear_with_fault: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fault_in && clear_all |=> hist[1] == '0 && hist[DEPTH-1] == '0)
		else $error("clear lost beside a fault");
	// Trip, output stage and freeze
	a_output_off: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fault_in |-> !OUTPUT_EN_O ##1 !OUTPUT_EN_O)
		else $error("output stage stayed on");
	a_clear_resumes: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		state == FHL_TRIPPED && fault_clear && !fault_in |=> OUTPUT_EN_O || fault_in)
		else $error("output stayed off after clear");
	a_trip_holds: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		state == FHL_TRIPPED && (!fault_clear || fault_in) |=> state == FHL_TRIPPED)
		else $error("trip ended without clear");
	a_mon_frozen: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		FROZEN_O |=> MON_HELD_O == $past(MON_HELD_O))
		else $error("monitor moved while frozen");
	a_nofreeze_cfg: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		no_freeze |-> !FROZEN_O ##1 MON_HELD_O == $past(MON_LIVE_I))
		else $error("freeze not disabled");

	c_fault: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) fault_in);
	c_clear_log: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) clear_all);
	c_recover: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
		state == FHL_TRIPPED ##1 state == FHL_RUN);
	c_fault_clear_same: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fault_in && clear_all);
endmodule

/* File: sim/fhl_fault_src.sv */
`timescale 1ns/1ns
// Stand-in for the protection logic that raises faults
module fhl_fault_src
	import fhl_pkg::*;
(
	input wire logic CLK_I,
	output fhl_pkg::fhl_event_t fault_o
);
	// Quiet until the first fault
	initial fault_o = '0;

	// One-cycle strobe, fields scrambled once released
	task automatic pulse(input logic [7:0] c, input logic [15:0] s, input logic h);
		@(posedge CLK_I);
		fault_o <= '{strobe: 1'b1, code: c, sub: s, has_sub: h};
		@(posedge CLK_I);
		fault_o <= '{strobe: 1'b0, code: ~c, sub: ~s, has_sub: ~h};
	endtask
endmodule

/* File: sim/fhl_core_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module fhl_core_tb;
	import fhl_pkg::*;
	logic clk, rst_n, oen, frz;
	fhl_event_t ev; // Fault event from the model
	fhl_req_t req; // Register request
	logic [15:0] date, tod, rdata;
	logic [287:0] live, held; // Monitor values in and out
	int fail_count, n_checks;

	fhl_core dut (.CLK_I(clk), .RESET_N_I(rst_n), .FAULT_I(ev), .DATE_I(date), .TIME_I(tod),
		.REQ_I(req), .RDATA_O(rdata), .OUTPUT_EN_O(oen), .FROZEN_O(frz),
		.MON_LIVE_I(live), .MON_HELD_O(held));
	fhl_fault_src src (.CLK_I(clk), .fault_o(ev));

	////////////////////////////////////////////////////////////////
	// Clock and a live value that moves every cycle
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			live <= '0;
		end else begin
			live <= {18{live[15:0] + 16'h0001}};
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus cycles
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rdchk(input string n, input logic [5:0] a, input logic [15:0] e);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 `CHK(n, e, rdata)
	endtask

	////////////////////////////////////////////////////////////////
	// Eleven faults: the first one falls off the end
	task automatic t_log;
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			date <= 16'hd000 + 16'(i);
			tod <= 16'h7000 + 16'(i);
			src.pulse(8'h10 + 8'(i), 16'ha000 + 16'(i), i[0]);
		end
		for (int n = 0; n < 10; n++) begin
			rdchk("code", OFS_CODE_BASE + 6'(n), 16'h0010 + 16'(10 - n));
			rdchk("date", OFS_DATE_BASE + 6'(n), 16'hd000 + 16'(10 - n));
			rdchk("time", OFS_TIME_BASE + 6'(n), 16'h7000 + 16'(10 - n));
			rdchk("sub", OFS_SUB_BASE + 6'(n), n[0] ? 16'ha000 + 16'(10 - n) : 16'h0000);
		end
		rdchk("status", OFS_STATUS, 16'h0003);
		`CHK("oen", 1'b0, oen)
		$display("t_log done");
	endtask

	////////////////////////////////////////////////////////////////
	// Freeze on fault, then freeze turned off by config
	task automatic t_freeze;
		logic [287:0] snap;
		wr(OFS_FAULT_CLR, FAULT_CLR_KEY);
		#1 `CHK("oen", 1'b1, oen)
		`CHK("frozen", 1'b0, frz)
		// Held values resume one edge after the clear
		@(posedge clk);
		#1 `CHK("track", {18{live[15:0] - 16'h0001}}, held)
		src.pulse(8'h21, 16'h0000, 1'b0);
		#1 snap = held;
		repeat (5) @(posedge clk);
		#1 `CHK("held", snap, held)
		`CHK("frozen", 1'b1, frz)
		`CHK("oen", 1'b0, oen)
		wr(OFS_FAULT_CLR, FAULT_CLR_KEY);
		wr(OFS_BEHAV_CFG, 16'h0010);
		rdchk("cfg", OFS_BEHAV_CFG, 16'h0010);
		src.pulse(8'h22, 16'h0000, 1'b0);
		repeat (3) @(posedge clk);
		#1 `CHK("frozen", 1'b0, frz)
		`CHK("track", {18{live[15:0] - 16'h0001}}, held)
		`CHK("oen", 1'b0, oen)
		$display("t_freeze done");
	endtask

	////////////////////////////////////////////////////////////////
	// Only the clear code wipes the logs
	task automatic t_clear;
		wr(OFS_HIST_CMD, 16'h00fe);
		rdchk("keep", OFS_CODE_BASE, 16'h0022);
		wr(OFS_HIST_CMD, CMD_CLEAR_ALL);
		rdchk("code0", OFS_CODE_BASE, 16'h0000);
		rdchk("time9", OFS_TIME_BASE + 6'h09, 16'h0000);
		rdchk("unmapped", 6'h3f, 16'h0000);
		$display("t_clear done");
	endtask

	////////////////////////////////////////////////////////////////
	// Fault in the same cycle as a log clear, then as a trip clear
	task automatic t_race;
		fork
			wr(OFS_HIST_CMD, CMD_CLEAR_ALL);
			src.pulse(8'h31, 16'h0005, 1'b1);
		join
		rdchk("race0", OFS_CODE_BASE, 16'h0031);
		rdchk("racesub", OFS_SUB_BASE, 16'h0005);
		rdchk("race1", OFS_CODE_BASE + 6'h01, 16'h0000);
		fork
			wr(OFS_FAULT_CLR, FAULT_CLR_KEY);
			src.pulse(8'h32, 16'h0000, 1'b0);
		join
		#1 `CHK("oen", 1'b0, oen)
		rdchk("stat", OFS_STATUS, 16'h0001);
		rdchk("race2", OFS_CODE_BASE + 6'h01, 16'h0031);
		$display("t_race done");
	endtask

	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		fail_count = 0;
		n_checks = 0;
		rst_n = 1'b0;
		req = '0;
		date = '0;
		tod = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_log;
		t_freeze;
		t_clear;
		t_race;
		close_out;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("BAD timeout");
		close_out;
	end
endmodule
